//--- dsbcd_pkg.sv
/*
 * dsbcd_pkg: shared constants, register map and carrier types of the
 * digit scan bcd output block.
 * assumes: a single 200 MHz core clock; registers reached over a 32-bit apb.
 */
package dsbcd_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ = 200_000_000;     // core clock rate
   localparam int unsigned SCAN_FREQ_HZ = 2_000;          // internal scan clock, 2 kHz
   localparam int unsigned SCAN_HALF_CYCLES = CLK_FREQ_HZ / (2 * SCAN_FREQ_HZ); // half period in cycles
   localparam int unsigned SCAN_SLOT_US = 500;            // one scan period, 500 us
   localparam int unsigned SCAN_CYCLE_US = 4_000;         // one whole scan pass, about 4 ms
   localparam int unsigned NUM_SLOTS = SCAN_CYCLE_US / SCAN_SLOT_US; // slots per pass
   localparam int unsigned NUM_DIGITS = NUM_SLOTS - 1;    // the slots less slot zero
   localparam int unsigned EXT_SCAN_MAX_HZ = 1_000_000;   // fastest external scan clock
   localparam int unsigned GATE_OVF_FACTOR = 10;          // gate stretch that overflows

   // ---------------------------------------------------------------
   // widths and codes
   // ---------------------------------------------------------------
   localparam int unsigned BCD_W = 4;                     // one bcd digit, 8-4-2-1
   localparam int unsigned SLOT_W = 4;                    // slot counter width
   localparam int unsigned GATE_W = 8;                    // gate factor field width
   localparam int unsigned IRQ_W = 2;                     // interrupt sources
   localparam logic [BCD_W-1:0] BCD_ZERO = 4'h0;          // blank digit
   localparam logic [BCD_W-1:0] BCD_NINE = 4'h9;          // largest digit

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;      // control
   localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;    // scan state
   localparam logic [ADDR_W-1:0] IRQ_STS_OFS = 12'h008;   // sticky events, write one to clear
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 12'h00c;  // interrupt enables
   localparam logic [ADDR_W-1:0] DIGIT_BASE = 12'h010;    // digit 0 (msd) upward, one word each

   // control fields
   localparam int unsigned CTRL_MAN_BIT = 0;              // manual accumulate mode
   localparam int unsigned CTRL_OVFCLR_BIT = 1;           // write one: clear overflow
   localparam int unsigned CTRL_COUNT_BIT = 2;            // write one: one input count
   localparam int unsigned CTRL_GATE_LSB = 8;             // gate stretch factor
   // status fields
   localparam int unsigned STS_SLOT_LSB = 0;
   localparam int unsigned STS_OVF_BIT = 8;
   localparam int unsigned STS_EXT_BIT = 9;
   // interrupt bits
   localparam int unsigned IRQ_CYCLE_BIT = 0;             // new scan pass began
   localparam int unsigned IRQ_OVF_BIT = 1;               // overflow went high

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic slot_zero_n;                                  // slot zero marker, low active
      logic leading_digit_pulse;                          // high during the msd slot
      logic [BCD_W-1:0] bcd;                              // 8,4,2,1 lines
   } dsbcd_scan_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } dsbcd_apb_req_type;

   typedef enum logic [1:0] {
      SRC_INT = 2'b01,                                    // internal 2 kHz scan clock
      SRC_EXT = 2'b10                                     // external scan clock pin
   } dsbcd_src_type;

endpackage

//--- dsbcd_digit_mem.sv
/*
 * dsbcd_digit_mem: small digit store, one write port, one registered
 * read port.
 * assumes: write and read on the same core clock; read data one cycle late.
 */
`timescale 1ns/100ps
module dsbcd_digit_mem #(
   parameter int unsigned DEPTH = 7,
   parameter int unsigned WIDTH = 4,
   parameter int unsigned AW = 3
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];  // digit cells, no reset needed

   // write port
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // registered read port, out of range reads as zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (32'(rd_addr) < DEPTH) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= '0;
      end
   end

endmodule

//--- dsbcd_scan_sync.sv
/*
 * dsbcd_scan_sync: brings the external scan clock and the scan clock
 * disable pin into the core domain and finds the rising scan edges.
 * assumes: both pins are asynchronous to core_clk and far slower than it.
 */
`timescale 1ns/100ps
module dsbcd_scan_sync (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ext_scan_clk,
   input wire logic scan_clk_dis_n,
   output logic ext_rise,
   output logic int_enable
);

   // ---------------------------------------------------------------
   // two-stage synchronisers
   // ---------------------------------------------------------------
   logic [1:0] clk_sync;  // clk_sync[0] only feeds clk_sync[1]
   logic [1:0] dis_sync;  // dis_sync[0] only feeds dis_sync[1]
   logic clk_last;        // previous synced clock level

   // shift the pins in; reset as if the internal clock were enabled
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_sync <= 2'h0;
         dis_sync <= 2'h3;
      end else begin
         clk_sync <= {clk_sync[0], ext_scan_clk};
         dis_sync <= {dis_sync[0], scan_clk_dis_n};
      end
   end

   // edge finder works on the second stage only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_last <= 1'b0;
         ext_rise <= 1'b0;
         int_enable <= 1'b1;
      end else begin
         clk_last <= clk_sync[1];
         ext_rise <= clk_sync[1] & ~clk_last;
         int_enable <= dis_sync[1];
      end
   end

endmodule

//--- dsbcd_top.sv
/*
 * dsbcd_top: multiplexed digit scan output with bcd lines, slot zero and
 * leading digit markers, overflow flag, apb registers and one interrupt.
 * assumes: apb master in the core clock domain; scan pins asynchronous.
 */
// Function
// - internal 2 kHz scan clock while enabled
// - digits msd first, step on rising edge
// - bcd lines held one scan period
// - every marker lasts one scan period
// - full pass about 4 ms internally
// - disable low selects external scan clock
// - slot timing scales with external period
// - low slot zero marker once per pass
// - slot zero directly precedes the msd
// - high leading pulse during msd slot
// - overflow on count after all nines
// - overflow on gate stretch of ten
// - overflow output follows overflow indicator
// - positive logic bcd lines 8-4-2-1
`timescale 1ns/100ps
module dsbcd_top #(
   parameter int unsigned SCAN_HALF = dsbcd_pkg::SCAN_HALF_CYCLES,
   parameter int unsigned DIGITS = dsbcd_pkg::NUM_DIGITS
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire dsbcd_pkg::dsbcd_apb_req_type apb_req,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic ext_scan_clk,
   input wire logic scan_clk_dis_n,
   output logic scan_clk_out,
   output dsbcd_pkg::dsbcd_scan_type scan_out,
   output logic overflow_out,
   output logic overflow_lamp,
   output logic irq
);
   import dsbcd_pkg::*;

   localparam int unsigned DIG_AW = $clog2(DIGITS);        // digit address width
   localparam int unsigned DIV_W = $clog2(SCAN_HALF + 1);  // divider width
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCAN_HALF - 1);
   localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(DIGITS); // least significant digit slot
   localparam logic [SLOT_W-1:0] SLOT_MSD = 4'h1;          // leading digit slot
   localparam logic [SLOT_W-1:0] SLOT_ZERO = 4'h0;         // slot zero marker slot

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   // true when the address hits a digit word
   function automatic logic digit_hit(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel = a - DIGIT_BASE;
      digit_hit = (a >= DIGIT_BASE) && (a[1:0] == 2'h0) && (32'(rel[ADDR_W-1:2]) < DIGITS);
   endfunction

   // digit index of a digit word address
   function automatic logic [DIG_AW-1:0] digit_index(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel = a - DIGIT_BASE;
      digit_index = rel[DIG_AW+1:2];
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   dsbcd_src_type src;                 // active scan clock source
   dsbcd_src_type next_src;
   logic [DIV_W-1:0] div_cnt;          // internal half period counter
   logic [SLOT_W-1:0] slot;            // current slot, zero is the marker slot
   logic [1:0] step_d;                 // step delayed while digit is fetched
   logic man_mode;                     // manual accumulate mode
   logic [GATE_W-1:0] gate_factor;     // gate stretch factor
   logic overflow;                     // overflow indicator
   logic [DIGITS-1:0] nine_mask;       // digit holds a nine
   logic [IRQ_W-1:0] irq_sts;          // sticky events
   logic [IRQ_W-1:0] irq_mask;         // event enables
   logic ext_rise;                     // synced external rising edge
   logic int_enable;                   // synced disable pin, high keeps internal clock
   logic [BCD_W-1:0] mem_rd;           // fetched digit

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   dsbcd_scan_sync u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ext_scan_clk(ext_scan_clk),
      .scan_clk_dis_n(scan_clk_dis_n),
      .ext_rise(ext_rise),
      .int_enable(int_enable)
   );

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   wire apb_access = apb_req.psel & apb_req.penable;          // access phase
   wire apb_fire = apb_access & pready;                       // completing edge
   wire apb_wr = apb_fire & apb_req.pwrite;                   // write takes effect
   wire hit_ctrl = apb_req.paddr == CTRL_OFS;
   wire hit_status = apb_req.paddr == STATUS_OFS;
   wire hit_ists = apb_req.paddr == IRQ_STS_OFS;
   wire hit_imask = apb_req.paddr == IRQ_MASK_OFS;
   wire hit_digit = digit_hit(apb_req.paddr);
   wire hit_any = hit_ctrl | hit_status | hit_ists | hit_imask | hit_digit;
   wire wr_ctrl = apb_wr & hit_ctrl;
   wire wr_ists = apb_wr & hit_ists;
   wire wr_imask = apb_wr & hit_imask;
   wire wr_digit = apb_wr & hit_digit;
   wire [DIG_AW-1:0] wr_digit_idx = digit_index(apb_req.paddr);
   wire [BCD_W-1:0] wr_digit_val = apb_req.pwdata[BCD_W-1:0];

   // read views
   wire [31:0] ctrl_view = {16'h0000, gate_factor, 7'h00, man_mode};
   wire [31:0] status_view = {22'h000000, src == SRC_EXT, overflow, 4'h0, slot};
   wire [31:0] ists_view = {30'h00000000, irq_sts};
   wire [31:0] imask_view = {30'h00000000, irq_mask};
   wire [31:0] rd_view = hit_ctrl ? ctrl_view :
                         hit_status ? status_view :
                         hit_ists ? ists_view :
                         hit_imask ? imask_view : 32'h00000000;

   // one wait state, then answer from registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_access & ~pready;
         prdata <= (apb_access & ~pready & ~apb_req.pwrite) ? rd_view : 32'h00000000;
         pslverr <= apb_access & ~pready & ~hit_any;
      end
   end

   // ---------------------------------------------------------------
   // scan clock source
   // ---------------------------------------------------------------
   // disable pin picks source
   always_comb begin
      next_src = src;
      unique case (src)
         SRC_INT: if (!int_enable) next_src = SRC_EXT;
         SRC_EXT: if (int_enable) next_src = SRC_INT;
         default: next_src = SRC_INT;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         src <= SRC_INT;
      end else begin
         src <= next_src;
      end
   end

   // internal square wave, stops low under an external clock
   wire div_wrap = (src == SRC_INT) && (div_cnt == DIV_LAST);
   wire int_tick = div_wrap & ~scan_clk_out;                   // internal rising edge
   wire step = (src == SRC_INT) ? int_tick : ext_rise;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= '0;
         scan_clk_out <= 1'b0;
      end else if (src != SRC_INT) begin
         div_cnt <= '0;
         scan_clk_out <= 1'b0;
      end else if (div_wrap) begin
         div_cnt <= '0;
         scan_clk_out <= ~scan_clk_out;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // digit sequencer
   // ---------------------------------------------------------------
   // eight slot pass
   wire [SLOT_W-1:0] next_slot = (slot == SLOT_LAST) ? SLOT_ZERO : slot + 1'b1;
   wire [SLOT_W-1:0] slot_m1 = slot - 1'b1;
   wire [DIG_AW-1:0] rd_idx = slot_m1[DIG_AW-1:0];
   wire load = step_d[1];                                    // digit fetched, update pins
   wire cycle_evt = step & (slot == SLOT_LAST);              // next slot is slot zero

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // start in the lsd slot so the first step shows the marker
         slot <= SLOT_LAST;
         step_d <= 2'h0;
      end else begin
         step_d <= {step_d[0], step};
         if (step) begin
            slot <= next_slot;
         end
      end
   end

   dsbcd_digit_mem #(
      .DEPTH(DIGITS),
      .WIDTH(BCD_W),
      .AW(DIG_AW)
   ) u_mem (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wr_en(wr_digit),
      .wr_addr(wr_digit_idx),
      .wr_data(wr_digit_val),
      .rd_addr(rd_idx),
      .rd_data(mem_rd)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_out.slot_zero_n <= 1'b1;
         scan_out.leading_digit_pulse <= 1'b0;
         scan_out.bcd <= BCD_ZERO;
      end else if (load) begin
         scan_out.slot_zero_n <= slot != SLOT_ZERO;
         scan_out.leading_digit_pulse <= slot == SLOT_MSD;
         scan_out.bcd <= (slot == SLOT_ZERO) ? BCD_ZERO : mem_rd;
      end
   end

   // ---------------------------------------------------------------
   // control and overflow
   // ---------------------------------------------------------------
   wire all_nines = &nine_mask;
   wire ovf_count = wr_ctrl & apb_req.pwdata[CTRL_COUNT_BIT] & man_mode & all_nines;
   wire ovf_gate = ~man_mode & (32'(gate_factor) >= GATE_OVF_FACTOR);
   wire ovf_set = ovf_count | ovf_gate;
   wire ovf_clr = wr_ctrl & apb_req.pwdata[CTRL_OVFCLR_BIT];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         man_mode <= 1'b0;
         gate_factor <= '0;
      end else if (wr_ctrl) begin
         man_mode <= apb_req.pwdata[CTRL_MAN_BIT];
         gate_factor <= apb_req.pwdata[CTRL_GATE_LSB +: GATE_W];
      end
   end

   // track which digits hold a nine
   genvar gi;
   generate
      for (gi = 0; gi < DIGITS; gi++) begin : g_nine
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               nine_mask[gi] <= 1'b0;
            end else if (wr_digit && (32'(wr_digit_idx) == gi)) begin
               nine_mask[gi] <= wr_digit_val == BCD_NINE;
            end
         end
      end
   endgenerate

   // output and indicator together; set beats clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow <= 1'b0;
         overflow_out <= 1'b0;
         overflow_lamp <= 1'b0;
      end else begin
         overflow <= ovf_set | (overflow & ~ovf_clr);
         overflow_out <= ovf_set | (overflow & ~ovf_clr);
         overflow_lamp <= ovf_set | (overflow & ~ovf_clr);
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   wire [IRQ_W-1:0] irq_set = {ovf_set & ~overflow, cycle_evt};
   wire [IRQ_W-1:0] irq_clr = wr_ists ? apb_req.pwdata[IRQ_W-1:0] : '0;

   // sticky events, a new event wins over a clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_sts <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         irq_sts <= irq_set | (irq_sts & ~irq_clr);
         if (wr_imask) begin
            irq_mask <= apb_req.pwdata[IRQ_W-1:0];
         end
         irq <= |(irq_sts & irq_mask);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_INT_TOGGLE: assert property (@(posedge core_clk) disable iff (!rst_n)
      div_wrap |=> scan_clk_out != $past(scan_clk_out))
      else $error("internal scan clock did not toggle at divider wrap");

   AST_EXT_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
      src == SRC_EXT |=> !scan_clk_out && !$rose(div_cnt[0]))
      else $error("internal scan clock ran while disabled");

   AST_SLOT_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n)
      step && slot != SLOT_LAST |=> slot == $past(slot) + 4'h1)
      else $error("slot did not advance by one");

   AST_SLOT_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
      step && slot == SLOT_LAST |=> slot == SLOT_ZERO)
      else $error("slot did not wrap to slot zero");

   AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      !load |=> $stable(scan_out))
      else $error("scan pins changed inside a slot");

   AST_LOAD_LAG: assert property (@(posedge core_clk) disable iff (!rst_n)
      step |-> ##2 load)
      else $error("pins not updated two cycles after the step");

   AST_ZERO_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(scan_out.leading_digit_pulse) |-> $past(scan_out.slot_zero_n) == 1'b0)
      else $error("leading pulse not preceded by slot zero");

   AST_MARK_APART: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(scan_out.leading_digit_pulse && !scan_out.slot_zero_n))
      else $error("markers overlap");

   AST_OVF_CAUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(overflow_out) |-> $past(ovf_count || ovf_gate))
      else $error("overflow rose without a cause");

   AST_OVF_LAMP: assert property (@(posedge core_clk) disable iff (!rst_n)
      ovf_gate |=> overflow_out && overflow_lamp)
      else $error("overflow output or indicator missed gate overflow");

endmodule

//--- dsbcd_capture.sv
/* dsbcd_capture: far side bcd capture logic of the digit scan.
   assumes: scan clock far slower than core_clk; sampled by it. */
`timescale 1ns/100ps
module dsbcd_capture (
   input wire logic core_clk,
   input wire logic scan_clk,
   input wire dsbcd_pkg::dsbcd_scan_type scan_out,
   output logic [27:0] digs
);
   import dsbcd_pkg::*;
   logic prev = 1'b0; // scan clock seen one cycle ago
   logic [3:0] idx = 4'h0; // digit slot being captured
   always @(posedge core_clk) begin
      prev <= scan_clk;
      if (prev && !scan_clk) begin
         idx <= scan_out.slot_zero_n ? idx + 4'h1 : 4'h0;
         if (scan_out.slot_zero_n && idx < 4'h7) digs[idx*4 +: 4] <= scan_out.bcd;
      end
   end
endmodule

//--- tb_top.sv
/* tb_top: self-checking bench of dsbcd_top.
   assumes: dsbcd_capture as the far side; short scan half period. */
`timescale 1ns/100ps
module tb_top;
   import dsbcd_pkg::*;
   localparam int HALF = 4; // core cycles per scan half period
   logic core_clk = 0, rst_n = 0, ext_scan_clk = 0, scan_clk_dis_n = 1, ext_on = 0;
   logic pready, pslverr, scan_clk_out, overflow_out, overflow_lamp, irq, err;
   logic [31:0] prdata, rd;
   logic [27:0] digs;
   logic [3:0] lead_bcd;
   dsbcd_apb_req_type apb_req = '0;
   dsbcd_scan_type scan_out;
   int mismatches = 0, checks_done = 0;
   int zc = 0, zlen = 0, lc = 0, llen = 0, cc = 0, clen = 0, pc = 0, plen = 0;
   initial forever #2.5 core_clk = ~core_clk;
   // link clock, scaled rate
   // link clock of 80 ns, held low outside external mode
   always #40 ext_scan_clk = ext_on & ~ext_scan_clk;
   dsbcd_top #(.SCAN_HALF(HALF), .DIGITS(7)) i_dsbcd_top (.core_clk(core_clk), .rst_n(rst_n),
      .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_scan_clk(ext_scan_clk),
      .scan_clk_dis_n(scan_clk_dis_n), .scan_clk_out(scan_clk_out), .scan_out(scan_out),
      .overflow_out(overflow_out), .overflow_lamp(overflow_lamp), .irq(irq));
   dsbcd_capture i_dsbcd_capture (.core_clk(core_clk), .scan_clk(ext_on ? ext_scan_clk : scan_clk_out),
      .scan_out(scan_out), .digs(digs));
   // pulse and period meters on pre-edge values
   always @(posedge core_clk) begin
      if (!scan_out.slot_zero_n && zc == 0) plen = pc;
      pc = (!scan_out.slot_zero_n && zc == 0) ? 1 : pc + 1;
      if (scan_out.slot_zero_n && zc != 0) zlen = zc;
      zc = scan_out.slot_zero_n ? 0 : zc + 1;
      if (!scan_out.leading_digit_pulse && lc != 0) llen = lc;
      lc = scan_out.leading_digit_pulse ? lc + 1 : 0;
      if (scan_out.leading_digit_pulse) lead_bcd = scan_out.bcd;
      if (!scan_clk_out && cc != 0) clen = cc;
      cc = scan_clk_out ? cc + 1 : 0;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1 && ++n < 40);
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
      if (n >= 40) chk("pready", 32'h1, 32'h0);
   endtask
   task automatic set_digs(input int b, input int s);
      for (int i = 0; i < 7; i++) apb(1'b1, DIGIT_BASE + 12'(4 * i), 32'(b + s * i));
   endtask
   function automatic logic [27:0] exp_digs(input int b, input int s);
      for (int i = 0; i < 7; i++) exp_digs[4*i +: 4] = 4'(b + s * i);
   endfunction
   task automatic s_regs;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      apb(1'b1, IRQ_MASK_OFS, 32'h2);
      apb(1'b0, IRQ_MASK_OFS, 32'h0);
      chk("mask", 32'h2, rd);
   endtask
   task automatic s_int;
      set_digs(1, 1);
      repeat (300) @(posedge core_clk);
      chk("clk half", 32'(HALF), 32'(clen));
      chk("zero len", 32'(2 * HALF), 32'(zlen));
      chk("lead len", 32'(2 * HALF), 32'(llen));
      chk("lead digit", 32'h1, 32'(lead_bcd));
      chk("pass len", 32'(16 * HALF), 32'(plen));
      chk("digits", 32'(exp_digs(1, 1)), 32'(digs));
   endtask
   task automatic s_ovf;
      chk("ovf rest", 32'h0, 32'(overflow_out));
      set_digs(9, 0);
      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b1, CTRL_OFS, 32'h5);
      repeat (4) @(posedge core_clk);
      chk("ovf count", 32'h1, 32'(overflow_out));
      chk("irq on", 32'h1, 32'(irq));
      apb(1'b1, CTRL_OFS, 32'h0902);
      apb(1'b1, IRQ_STS_OFS, 32'h3);
      repeat (4) @(posedge core_clk);
      chk("gate nine", 32'h0, 32'(overflow_lamp));
      chk("irq off", 32'h0, 32'(irq));
      apb(1'b1, CTRL_OFS, 32'h0a00);
      repeat (4) @(posedge core_clk);
      chk("gate ten", 32'h1, 32'(overflow_out));
      chk("lamp", 32'h1, 32'(overflow_lamp));
      apb(1'b1, CTRL_OFS, 32'h0002);
      repeat (2) @(posedge core_clk);
      chk("set wins", 32'h1, 32'(overflow_out));
      apb(1'b1, CTRL_OFS, 32'h0002);
      repeat (2) @(posedge core_clk);
      chk("ovf clear", 32'h0, 32'(overflow_out));
      chk("lamp clear", 32'h0, 32'(overflow_lamp));
   endtask
   task automatic s_ext;
      scan_clk_dis_n <= 1'b0;
      ext_on <= 1'b1;
      set_digs(8, -1);
      repeat (400) @(posedge core_clk);
      chk("int held", 32'h0, 32'(scan_clk_out));
      chk("ext zero", 32'd16, 32'(zlen));
      chk("ext pass", 32'd128, 32'(plen));
      chk("ext digits", 32'(exp_digs(8, -1)), 32'(digs));
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status ext", 32'h1, 32'(rd[STS_EXT_BIT]));
      ext_on <= 1'b0;
   endtask
   task close_out;
      $display("Counts: %0d mismatches, %0d checks", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      s_regs();
      s_int();
      s_ovf();
      s_ext();
      close_out();
   end
   // watchdog well past the planned run
   initial begin
      #50000;
      mismatches++;
      close_out();
   end
endmodule
